// [include/lan_init_pkg.sv]
// Constants, encodings and field layouts for the coprocessor start-up sequencer and host port.
// Assumes a single 200 MHz system clock and a shared-memory master outside the block.
package lan_init_pkg;

  localparam logic [31:0] DEFAULT_SCP_ADDR = 32'h00FF_FFF4;
  localparam logic [3:0]  FN_SW_RESET      = 4'h0;
  localparam logic [3:0]  FN_SELF_TEST     = 4'h1;
  localparam logic [3:0]  FN_ALT_SCP       = 4'h2;
  localparam logic [3:0]  FN_DUMP          = 4'h3;
  localparam logic [31:0] ADDR_ALIGN_MASK  = 32'hFFFF_FFF0;

  // Byte offsets inside the configuration pointer, intermediate pointer and control block.
  localparam logic [31:0] SCP_SYSBUS_OFS   = 32'h0000_0000;
  localparam logic [31:0] SCP_INTERMEDIATE_CONFIG_POINTER_OFS     = 32'h0000_0008;
  localparam logic [31:0] INTERMEDIATE_CONFIG_POINTER_BUSY_OFS    = 32'h0000_0000;
  localparam logic [31:0] INTERMEDIATE_CONFIG_POINTER_BASE_OFS    = 32'h0000_0004;
  localparam logic [31:0] SCB_STATUS_OFS   = 32'h0000_0000;

  // Dump area: index of the last word written, and the byte stride between words.
  localparam logic [31:0] DUMP_LAST_WORD   = 32'h0000_0003;
  localparam logic [31:0] DUMP_STRIDE      = 32'h0000_0004;

  // Field positions in the system-bus byte.
  localparam int SYSBUS_MODE_LSB  = 1;
  localparam int SYSBUS_TRG_BIT   = 3;
  localparam int SYSBUS_LOCK_BIT  = 4;
  localparam int SYSBUS_INTP_BIT  = 5;

  localparam logic [1:0]  MODE_COMPAT      = 2'h0;
  localparam logic [1:0]  MODE_SEG32       = 2'h1;
  localparam logic [1:0]  MODE_LINEAR      = 2'h2;

  // Status word written to the control block: done and not-ready set, command cleared.
  localparam logic [31:0] SCB_DONE_WORD    = 32'h0000_A000;
  localparam logic [31:0] ZERO_WORD        = 32'h0000_0000;
  localparam logic [15:0] THROTTLE_ON_INF  = 16'hFFFF;
  localparam logic [15:0] THROTTLE_OFF_ZERO = 16'h0000;

  localparam int  CLK_PERIOD_PS    = 5000;
  localparam int  RESET_HOLD_NS    = 50;
  localparam int  RESET_HOLD_CYC   = (RESET_HOLD_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

  typedef enum logic [1:0] {
    MEM_READ,
    MEM_WRITE
  } mem_op_t;

endpackage : lan_init_pkg

// [hdl/port_cmd_capture.sv]
// Host access port: assembles two 16-bit writes into one 32-bit command.
// Assumes the host drives port_sel for one cycle per write with data on wr_data.
`timescale 1ns/1ps
module port_cmd_capture (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        port_sel,
  input  wire logic [15:0] wr_data,
  output logic             halt,
  output logic             cmd_valid,
  output logic [31:0]      cmd_word
);
  import lan_init_pkg::*;

  logic        halt_r,  halt_nxt;
  logic        valid_r, valid_nxt;
  logic [15:0] low_r,   low_nxt;
  logic [31:0] word_r,  word_nxt;

  always_comb begin
    halt_nxt  = halt_r;
    valid_nxt = 1'b0;
    low_nxt   = low_r;
    word_nxt  = word_r;
    if (port_sel) begin
      if (!halt_r) begin
        halt_nxt = 1'b1;
        low_nxt  = wr_data;
      end else begin
        halt_nxt  = 1'b0;
        valid_nxt = 1'b1;
        word_nxt  = {wr_data, low_r};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      halt_r  <= 1'b0;
      valid_r <= 1'b0;
      low_r   <= 16'h0000;
      word_r  <= 32'h0000_0000;
    end else begin
      halt_r  <= halt_nxt;
      valid_r <= valid_nxt;
      low_r   <= low_nxt;
      word_r  <= word_nxt;
    end
  end

  assign halt      = halt_r;
  assign cmd_valid = valid_r;
  assign cmd_word  = word_r;

endmodule : port_cmd_capture

// [hdl/lan_init_seq.sv]
// Start-up sequencer of the coprocessor with its host access port.
// Assumes a simple memory master outside: one request held until mem_ack, read data with ack.
`timescale 1ns/1ps
module lan_init_seq #(
  parameter int SELFTEST_CYCLES = 16,
  parameter int SW_RESET_CYCLES = lan_init_pkg::RESET_HOLD_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic        attention_strobe,
  input  wire logic        port_sel,
  input  wire logic [15:0] port_data,
  output logic             mem_req,
  output logic             mem_we,
  output logic [31:0]      mem_addr,
  output logic [31:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             host_irq,
  output logic             init_done,
  output logic             busy,
  output logic [1:0]       op_mode,
  output logic             throttle_trigger,
  output logic             irq_active_low,
  output logic             lock_enable,
  output logic [31:0]      scb_base,
  output logic [15:0]      scb_offset,
  output logic [15:0]      throttle_on,
  output logic [15:0]      throttle_off,
  output logic             selftest_pass
);
  import lan_init_pkg::*;

  if (SELFTEST_CYCLES < 1 || SW_RESET_CYCLES < 1) begin : g_bad_counts
    $error("Cycle counts must be at least one");
  end

  typedef enum logic [3:0] {
    S_WAIT_CA,
    S_RD_SYSBUS,
    S_RD_INTERMEDIATE_CONFIG_POINTER_PTR,
    S_RD_OFFSET,
    S_RD_BASE,
    S_CLR_BUSY,
    S_WR_SCB,
    S_IDLE,
    S_SELFTEST,
    S_WR_RESULT,
    S_DUMP,
    S_SW_RESET
  } state_t;

  ////////////////////////////////////////////////////////////////////////////////////////
  // Port command capture.

  logic        port_halt;
  logic        cmd_valid;
  logic [31:0] cmd_word;

  port_cmd_capture u_port (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .port_sel  (port_sel),
    .wr_data   (port_data),
    .halt      (port_halt),
    .cmd_valid (cmd_valid),
    .cmd_word  (cmd_word)
  );

  ////////////////////////////////////////////////////////////////////////////////////////
  // Sequencer state.

  state_t      state_r,   state_nxt;
  logic        req_r,     req_nxt;
  logic        we_r,      we_nxt;
  logic [31:0] addr_r,    addr_nxt;
  logic [31:0] wdata_r,   wdata_nxt;
  logic        irq_r,     irq_nxt;
  logic        done_r,    done_nxt;
  logic [31:0] scp_r,     scp_nxt;
  logic [31:0] intermediate_config_pointer_r,    intermediate_config_pointer_nxt;
  logic [31:0] base_r,    base_nxt;
  logic [15:0] ofs_r,     ofs_nxt;
  logic [1:0]  mode_r,    mode_nxt;
  logic        trg_r,     trg_nxt;
  logic        intp_r,    intp_nxt;
  logic        lock_r,    lock_nxt;
  logic [15:0] ton_r,     ton_nxt;
  logic [15:0] toff_r,    toff_nxt;
  logic [31:0] parm_r,    parm_nxt;
  logic [31:0] cnt_r,     cnt_nxt;
  logic        pass_r,    pass_nxt;
  logic        busy_r,    busy_nxt;

  // A memory transaction is issued once and retired on the ack.
  function automatic logic issued(input logic r, input logic a);
    issued = r & a;
  endfunction : issued

  always_comb begin
    state_nxt = state_r;
    req_nxt   = req_r;
    we_nxt    = we_r;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;
    irq_nxt   = 1'b0;
    done_nxt  = done_r;
    scp_nxt   = scp_r;
    intermediate_config_pointer_nxt  = intermediate_config_pointer_r;
    base_nxt  = base_r;
    ofs_nxt   = ofs_r;
    mode_nxt  = mode_r;
    trg_nxt   = trg_r;
    intp_nxt  = intp_r;
    lock_nxt  = lock_r;
    ton_nxt   = ton_r;
    toff_nxt  = toff_r;
    parm_nxt  = parm_r;
    cnt_nxt   = cnt_r;
    pass_nxt  = pass_r;

    unique case (state_r)
      S_WAIT_CA: begin
        if (attention_strobe && !port_halt) begin
          state_nxt = S_RD_SYSBUS;
          req_nxt   = 1'b1;
          we_nxt    = 1'b0;
          addr_nxt  = scp_r + SCP_SYSBUS_OFS;
        end
      end
      S_RD_SYSBUS: begin
        if (issued(req_r, mem_ack)) begin
          mode_nxt  = mem_rdata[SYSBUS_MODE_LSB +: 2];
          trg_nxt   = mem_rdata[SYSBUS_TRG_BIT];
          lock_nxt  = mem_rdata[SYSBUS_LOCK_BIT];
          intp_nxt  = mem_rdata[SYSBUS_INTP_BIT];
          addr_nxt  = scp_r + SCP_INTERMEDIATE_CONFIG_POINTER_OFS;
          state_nxt = S_RD_INTERMEDIATE_CONFIG_POINTER_PTR;
        end
      end
      S_RD_INTERMEDIATE_CONFIG_POINTER_PTR: begin
        if (issued(req_r, mem_ack)) begin
          intermediate_config_pointer_nxt  = mem_rdata;
          addr_nxt  = mem_rdata + INTERMEDIATE_CONFIG_POINTER_BUSY_OFS;
          state_nxt = S_RD_OFFSET;
        end
      end
      S_RD_OFFSET: begin
        if (issued(req_r, mem_ack)) begin
          ofs_nxt   = mem_rdata[31:16];
          addr_nxt  = intermediate_config_pointer_r + INTERMEDIATE_CONFIG_POINTER_BASE_OFS;
          state_nxt = S_RD_BASE;
        end
      end
      S_RD_BASE: begin
        if (issued(req_r, mem_ack)) begin
          // Linear mode keeps the full absolute word; segmented modes keep base plus offset.
          if (mode_r == MODE_LINEAR) begin
            base_nxt = mem_rdata;
            ofs_nxt  = 16'h0000;
          end else if (mode_r == MODE_COMPAT) begin
            base_nxt = {8'h00, mem_rdata[23:0]};
          end else begin
            base_nxt = mem_rdata;
          end
          we_nxt    = 1'b1;
          addr_nxt  = intermediate_config_pointer_r + INTERMEDIATE_CONFIG_POINTER_BUSY_OFS;
          wdata_nxt = ZERO_WORD;
          state_nxt = S_CLR_BUSY;
        end
      end
      S_CLR_BUSY: begin
        if (issued(req_r, mem_ack)) begin
          addr_nxt  = base_r + {16'h0000, ofs_r} + SCB_STATUS_OFS;
          wdata_nxt = SCB_DONE_WORD;
          state_nxt = S_WR_SCB;
        end
      end
      S_WR_SCB: begin
        if (issued(req_r, mem_ack)) begin
          req_nxt   = 1'b0;
          we_nxt    = 1'b0;
          irq_nxt   = 1'b1;
          done_nxt  = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      S_IDLE: begin
        // Later attention strobes belong to the command and receive units.
      end
      S_SELFTEST: begin
        if (cnt_r == 32'd0) begin
          pass_nxt  = 1'b1;
          req_nxt   = 1'b1;
          we_nxt    = 1'b1;
          addr_nxt  = parm_r;
          wdata_nxt = ZERO_WORD;
          state_nxt = S_WR_RESULT;
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      S_WR_RESULT: begin
        if (issued(req_r, mem_ack)) begin
          req_nxt   = 1'b0;
          we_nxt    = 1'b0;
          state_nxt = done_r ? S_IDLE : S_WAIT_CA;
        end
      end
      S_DUMP: begin
        // Four words of internal state go out; cnt_r counts them.
        if (issued(req_r, mem_ack)) begin
          if (cnt_r == DUMP_LAST_WORD) begin
            req_nxt   = 1'b0;
            we_nxt    = 1'b0;
            state_nxt = done_r ? S_IDLE : S_WAIT_CA;
          end else begin
            cnt_nxt  = cnt_r + 32'd1;
            addr_nxt = addr_r + DUMP_STRIDE;
            unique case (cnt_r[1:0])
              2'd0:    wdata_nxt = base_r;
              2'd1:    wdata_nxt = {ofs_r, 11'h000, lock_r, intp_r, trg_r, mode_r};
              default: wdata_nxt = {ton_r, toff_r};
            endcase
          end
        end
      end
      S_SW_RESET: begin
        if (cnt_r == 32'd0) begin
          state_nxt = S_WAIT_CA;
        end else begin
          cnt_nxt = cnt_r - 32'd1;
        end
      end
      default: begin
        state_nxt = S_WAIT_CA;
      end
    endcase

    // Reset, self-test and dump override whatever the sequencer was doing.
    if (cmd_valid) begin
      unique case (cmd_word[3:0])
        FN_SW_RESET: begin
          state_nxt = S_SW_RESET;
          req_nxt   = 1'b0;
          we_nxt    = 1'b0;
          cnt_nxt   = 32'(SW_RESET_CYCLES);
          done_nxt  = 1'b0;
          ton_nxt   = THROTTLE_ON_INF;
          toff_nxt  = THROTTLE_OFF_ZERO;
          pass_nxt  = 1'b0;
        end
        FN_SELF_TEST: begin
          state_nxt = S_SELFTEST;
          req_nxt   = 1'b0;
          we_nxt    = 1'b0;
          parm_nxt  = cmd_word & ADDR_ALIGN_MASK;
          cnt_nxt   = 32'(SELFTEST_CYCLES);
          pass_nxt  = 1'b0;
        end
        FN_ALT_SCP: begin
          // Only the pointer changes, so a transfer in flight keeps its request up.
          scp_nxt = cmd_word & ADDR_ALIGN_MASK;
        end
        FN_DUMP: begin
          state_nxt = S_DUMP;
          req_nxt   = 1'b1;
          we_nxt    = 1'b1;
          addr_nxt  = cmd_word & ADDR_ALIGN_MASK;
          wdata_nxt = {27'h0, state_r, done_r};
          cnt_nxt   = 32'd0;
        end
        default: begin
        end
      endcase
    end

    busy_nxt = (state_nxt != S_WAIT_CA) && (state_nxt != S_IDLE);
  end

  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_r <= S_WAIT_CA;
      req_r   <= 1'b0;
      we_r    <= 1'b0;
      addr_r  <= 32'h0000_0000;
      wdata_r <= 32'h0000_0000;
      irq_r   <= 1'b0;
      done_r  <= 1'b0;
      scp_r   <= DEFAULT_SCP_ADDR;
      intermediate_config_pointer_r  <= 32'h0000_0000;
      base_r  <= 32'h0000_0000;
      ofs_r   <= 16'h0000;
      mode_r  <= MODE_COMPAT;
      trg_r   <= 1'b0;
      intp_r  <= 1'b0;
      lock_r  <= 1'b0;
      ton_r   <= THROTTLE_ON_INF;
      toff_r  <= THROTTLE_OFF_ZERO;
      parm_r  <= 32'h0000_0000;
      cnt_r   <= 32'h0000_0000;
      pass_r  <= 1'b0;
      busy_r  <= 1'b0;
    end else begin
      state_r <= state_nxt;
      req_r   <= req_nxt;
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
      irq_r   <= irq_nxt;
      done_r  <= done_nxt;
      scp_r   <= scp_nxt;
      intermediate_config_pointer_r  <= intermediate_config_pointer_nxt;
      base_r  <= base_nxt;
      ofs_r   <= ofs_nxt;
      mode_r  <= mode_nxt;
      trg_r   <= trg_nxt;
      intp_r  <= intp_nxt;
      lock_r  <= lock_nxt;
      ton_r   <= ton_nxt;
      toff_r  <= toff_nxt;
      parm_r  <= parm_nxt;
      cnt_r   <= cnt_nxt;
      pass_r  <= pass_nxt;
      busy_r  <= busy_nxt;
    end
  end

  assign mem_req          = req_r;
  assign mem_we           = we_r;
  assign mem_addr         = addr_r;
  assign mem_wdata        = wdata_r;
  assign host_irq         = irq_r;
  assign init_done        = done_r;
  assign busy             = busy_r;
  assign op_mode          = mode_r;
  assign throttle_trigger = trg_r;
  assign irq_active_low   = intp_r;
  assign lock_enable      = lock_r;
  assign scb_base         = base_r;
  assign scb_offset       = ofs_r;
  assign throttle_on      = ton_r;
  assign throttle_off     = toff_r;
  assign selftest_pass    = pass_r;

endmodule : lan_init_seq

// [verification/lan_init_seq_asserts.sv]
// Concurrent checks on the ports of the start-up sequencer.
// Assumes one clock domain and the synchronous active-high reset of the design.
`timescale 1ns/1ps
module lan_init_seq_checker (
  input wire logic        sys_clk,
  input wire logic        reset,
  input wire logic        attention_strobe,
  input wire logic        port_sel,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [31:0] mem_addr,
  input wire logic        mem_ack,
  input wire logic        host_irq,
  input wire logic        init_done,
  input wire logic        busy,
  input wire logic [15:0] throttle_on,
  input wire logic [15:0] throttle_off
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  ////////////////////////////////////////////////////////////////////////////////
  req_hold_a: assert property (
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we))
    else $error("memory request changed before its acknowledge");
  start_req_a: assert property (
    attention_strobe && !busy && !init_done && !port_sel && !$past(port_sel)
    |=> mem_req && !mem_we)
    else $error("attention after reset did not start a pointer read");
  ignore_cmd_a: assert property (
    attention_strobe && !busy && init_done && !port_sel && !$past(port_sel) |=> !mem_req)
    else $error("attention after completion started memory traffic");
  irq_pulse_a: assert property (host_irq |=> !host_irq)
    else $error("interrupt lasted more than one cycle");
  irq_done_a: assert property (host_irq |-> init_done)
    else $error("interrupt without completed initialisation");
  done_irq_a: assert property ($rose(init_done) |-> host_irq)
    else $error("completion without interrupt");
  reset_dflt_a: assert property (
    $fell(reset) |-> throttle_on == 16'hFFFF && throttle_off == 16'h0000 && !init_done)
    else $error("reset defaults wrong");
  idle_quiet_a: assert property (!busy |-> !mem_req)
    else $error("memory request while idle");
endmodule : lan_init_seq_checker

bind lan_init_seq lan_init_seq_checker i_chk (
  .sys_clk(sys_clk), .reset(reset), .attention_strobe(attention_strobe),
  .port_sel(port_sel), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
  .mem_ack(mem_ack), .host_irq(host_irq), .init_done(init_done), .busy(busy),
  .throttle_on(throttle_on), .throttle_off(throttle_off));

// [verification/mem_model.sv]
// Shared host memory answering the sequencer's request/acknowledge bus.
// Assumes requests are held until acknowledged; ack_delay sets extra wait cycles.
`timescale 1ns/1ps
module mem_model (
  input  wire logic        sys_clk,
  input  wire logic        reset,
  input  wire logic [3:0]  ack_delay,
  input  wire logic        mem_req,
  input  wire logic        mem_we,
  input  wire logic [31:0] mem_addr,
  input  wire logic [31:0] mem_wdata,
  output logic             mem_ack,
  output logic [31:0]      mem_rdata
);
  logic [31:0] mem [logic [31:0]];
  logic [31:0] alog [$];
  logic [3:0]  cnt_r;
  initial begin
    mem_ack = 1'b0;
    mem_rdata = 32'h0000_0000;
    cnt_r = 4'h0;
  end
  // Read data is toggled outside an acknowledge so stale data never looks valid.
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    if (reset) begin
      cnt_r <= 4'h0;
    end else if (mem_req && !mem_ack && cnt_r >= ack_delay) begin
      mem_ack <= 1'b1;
      cnt_r <= 4'h0;
      alog.push_back(mem_addr);
      if (mem_we) begin
        mem[mem_addr] = mem_wdata;
      end else begin
        mem_rdata <= mem.exists(mem_addr) ? mem[mem_addr] : ~mem_addr;
      end
    end else begin
      if (mem_req && !mem_ack) begin
        cnt_r <= cnt_r + 4'h1;
      end
      mem_rdata <= ~mem_rdata;
    end
  end
endmodule : mem_model

// [verification/testbench.sv]
// Self-checking bench for the start-up sequencer and its host access port.
// Assumes the memory model answers the bus and is preloaded by hierarchical writes.
`timescale 1ns/1ps
module testbench;
  import lan_init_pkg::*;
  logic        sys_clk, reset, attention_strobe, port_sel, mem_ack, mem_req, mem_we;
  logic        host_irq, init_done, busy, throttle_trigger, irq_active_low;
  logic        lock_enable, selftest_pass;
  logic [3:0]  ack_delay;
  logic [15:0] port_data, scb_offset, throttle_on, throttle_off;
  logic [31:0] mem_addr, mem_wdata, mem_rdata, scb_base;
  logic [1:0]  op_mode;
  int          n_fail = 0;
  int          samples_checked = 0;
  int          irq_cnt = 0;
  lan_init_seq #(.SELFTEST_CYCLES(2), .SW_RESET_CYCLES(1)) i_lan_init_seq (
    .sys_clk(sys_clk), .reset(reset), .attention_strobe(attention_strobe),
    .port_sel(port_sel), .port_data(port_data), .mem_req(mem_req), .mem_we(mem_we),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .host_irq(host_irq), .init_done(init_done), .busy(busy),
    .op_mode(op_mode), .throttle_trigger(throttle_trigger),
    .irq_active_low(irq_active_low), .lock_enable(lock_enable), .scb_base(scb_base),
    .scb_offset(scb_offset), .throttle_on(throttle_on), .throttle_off(throttle_off),
    .selftest_pass(selftest_pass));
  mem_model i_mem_model (
    .sys_clk(sys_clk), .reset(reset), .ack_delay(ack_delay), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) if (host_irq === 1'b1) irq_cnt++;
  task automatic finish_test;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : finish_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Low half carries the function code and goes first; both halves back to back.
  task automatic port_write(input logic [31:0] word);
    @(posedge sys_clk);
    port_sel  <= 1'b1;
    port_data <= word[15:0];
    @(posedge sys_clk);
    port_data <= word[31:16];
    @(posedge sys_clk);
    port_sel  <= 1'b0;
  endtask : port_write
  task automatic strobe;
    @(posedge sys_clk);
    attention_strobe <= 1'b1;
    @(posedge sys_clk);
    attention_strobe <= 1'b0;
  endtask : strobe
  task automatic wait_idle;
    int i;
    repeat (3) @(posedge sys_clk);
    for (i = 0; i < 200 && busy !== 1'b0; i++) @(posedge sys_clk);
    #1;
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    reset = 1'b1;
    attention_strobe = 1'b0;
    port_sel = 1'b0;
    port_data = 16'h0000;
    ack_delay = 4'h0;
    // Default pointer chain: segmented mode, trigger, lock and polarity all set.
    i_mem_model.mem[DEFAULT_SCP_ADDR] = 32'h0000_003A;
    i_mem_model.mem[DEFAULT_SCP_ADDR + SCP_INTERMEDIATE_CONFIG_POINTER_OFS] = 32'h0000_1000;
    i_mem_model.mem[32'h0000_1000] = 32'h0040_0001;
    i_mem_model.mem[32'h0000_1004] = 32'h1200_0000;
    repeat (3) @(posedge sys_clk);
    reset <= 1'b0;
    @(posedge sys_clk);
    #1;
    check(32'(throttle_on), 32'h0000_FFFF);
    check(32'(throttle_off), 32'h0000_0000);
    check(32'(init_done), 32'h0000_0000);
    strobe();
    wait_idle();
    check(i_mem_model.alog[0], DEFAULT_SCP_ADDR);
    check(32'({op_mode, throttle_trigger, lock_enable, irq_active_low}), 32'h0000_000F);
    check(scb_base, 32'h1200_0000);
    check(32'(scb_offset), 32'h0000_0040);
    check(i_mem_model.mem[32'h0000_1000], ZERO_WORD);
    check(i_mem_model.mem[32'h1200_0040], SCB_DONE_WORD);
    check(32'(init_done), 32'h0000_0001);
    check(32'(irq_cnt), 32'h0000_0001);
    // A second attention after completion must be ignored.
    i_mem_model.alog.delete();
    strobe();
    repeat (6) @(posedge sys_clk);
    check(32'(i_mem_model.alog.size()), 32'h0000_0000);
    // Alternate pointer in linear mode, then a software reset with junk address bits.
    i_mem_model.mem[32'h0000_2000] = 32'h0000_0004;
    i_mem_model.mem[32'h0000_2008] = 32'h0000_1000;
    i_mem_model.mem[32'h0000_1000] = 32'h0000_0001;
    i_mem_model.mem[32'h0000_1004] = 32'h3400_0000;
    port_write(32'h0000_2000 | 32'(FN_ALT_SCP));
    port_write(32'hFFFF_FFF0 | 32'(FN_SW_RESET));
    repeat (12) @(posedge sys_clk);
    #1;
    check(32'(init_done), 32'h0000_0000);
    ack_delay <= 4'h3;
    i_mem_model.alog.delete();
    strobe();
    wait_idle();
    check(i_mem_model.alog[0], 32'h0000_2000);
    check(32'(op_mode), 32'(MODE_LINEAR));
    check(scb_base, 32'h3400_0000);
    check(i_mem_model.mem[32'h3400_0000], SCB_DONE_WORD);
    check(32'(irq_cnt), 32'h0000_0002);
    // Dump writes four words from the given area.
    ack_delay <= 4'h0;
    i_mem_model.alog.delete();
    port_write(32'h0000_3000 | 32'(FN_DUMP));
    wait_idle();
    check(32'(i_mem_model.alog.size()), 32'h0000_0004);
    for (int k = 0; k < 4; k++) begin
      check(i_mem_model.alog[k], 32'h0000_3000 + 32'(4 * k));
    end
    // Self-test writes its result word at the given address.
    i_mem_model.alog.delete();
    port_write(32'h0000_4000 | 32'(FN_SELF_TEST));
    wait_idle();
    check(i_mem_model.alog[0], 32'h0000_4000);
    check(i_mem_model.mem[32'h0000_4000], ZERO_WORD);
    check(32'(selftest_pass), 32'h0000_0001);
    finish_test();
  end
  // The full sequence needs well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge sys_clk);
    n_fail++;
    finish_test();
  end
endmodule : testbench
